// file: core/acss_cfg.svh
`ifndef ACSS_CFG_SVH
`define ACSS_CFG_SVH
`define ACSS_NUM_IN 4
`define ACSS_NUM_OUT 2
`define ACSS_DATA_W 12
`define ACSS_WORD_W 16
`define ACSS_BIT_BUSY 12
`define ACSS_BIT_FAIL 13
`define ACSS_BIT_CH_LO 14
`define ACSS_BIT_CH_HI 15
`define ACSS_IN_WORD_RST 16'h1000
`define ACSS_REV_ZERO_MA 4
`define ACSS_REV_MAX_MA 40
`endif

// file: core/acss_pkg.sv
package acss_pkg;
  typedef logic [11:0] acss_data_t;
  typedef logic [1:0] acss_ch_t;
  typedef enum logic [1:0] {
    ACSS_ST_FIRST = 2'b00,
    ACSS_ST_RUN = 2'b01,
    ACSS_ST_FAIL = 2'b10
  } acss_state_e;
endpackage : acss_pkg

// file: core/acss_in_conv.sv
`timescale 1ns/1ps
`default_nettype none
`include "acss_cfg.svh"
// Current-to-count mapping; reversed loops fold to zero near zero.
module acss_in_conv
  import acss_pkg::*;
(
  input wire logic signed [15:0] ma_x16,
  output logic [11:0] count
);
  logic signed [15:0] rel;
  always_comb
  begin
    rel = 16'sh0000;
    count = 12'h000;
    if (ma_x16 < 0)
    begin
      // Within -4 mA reads zero; beyond gives the excess over 4 mA in 1/16 mA, low twelve bits kept
      if (ma_x16 < -(`ACSS_REV_ZERO_MA * 16))
        count = 12'(-ma_x16 - (`ACSS_REV_ZERO_MA * 16));
    end
    else if (ma_x16 > (`ACSS_REV_ZERO_MA * 16))
    begin
      rel = 16'(ma_x16 - (`ACSS_REV_ZERO_MA * 16));
      if (rel >= 16'sh0100)
        count = 12'hfff;
      else
        count = 12'(rel * 16);
    end
  end
endmodule : acss_in_conv
`default_nettype wire

// file: core/acss_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "acss_cfg.svh"
// How it works
// - Multiplexed mode delivers one input per scan
// - Four used channels complete within four scans
// - After last channel, wrap to channel one
// - Unused input channels are skipped
// - Pointer mode delivers all four per scan
// - Each scan updates every output whose select is low; both selects low updates both
// - Single used output updates every scan
// - Reversed input within 4 mA reads zero
// - Two bits code the active channel
// - Data sits in low twelve bits
// - Busy on first scan; fail zeroes data
module acss_seq
  import acss_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic SCAN_STB,
  input wire logic PTR_MODE,
  input wire logic [3:0] IN_USED,
  input wire logic [63:0] IN_MA_X16,
  input wire logic PWR_OK_ASYNC,
  input wire logic TERM_OK_ASYNC,
  input wire logic NOISE_ASYNC,
  input wire logic [11:0] OUT_WORD,
  input wire logic [1:0] OUT_SEL_N,
  output logic [15:0] IN_WORD,
  output logic [63:0] IN_ALL,
  output logic IN_ALL_VLD,
  output logic [11:0] AOUT1,
  output logic [11:0] AOUT2
);
  ////////////////////////////////////////////////////////////////////////////
  logic [11:0] conv [4];
  logic [2:0] sync1_q, sync2_q;
  for (genvar g = 0; g < `ACSS_NUM_IN; g++)
  begin : g_conv
    acss_in_conv u_conv (
      .ma_x16(IN_MA_X16[g*16 +: 16]),
      .count(conv[g])
    );
  end
  // Async status pins: two flops, second only read
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {NOISE_ASYNC, TERM_OK_ASYNC, PWR_OK_ASYNC};
      sync2_q <= sync1_q;
    end
  end
  wire logic fault = !(sync2_q[0] && sync2_q[1]);
  function automatic acss_ch_t next_used(input acss_ch_t cur, input logic [3:0] used);
    acss_ch_t n;
    n = cur;
    for (int i = 1; i <= 4; i++)
    begin
      if (used[2'(cur + 2'(i))] && n == cur)
        n = 2'(cur + 2'(i));
    end
    return n;
  endfunction : next_used
  ////////////////////////////////////////////////////////////////////////////
  acss_state_e st_q, st_d;
  acss_ch_t ch_q, ch_d;
  logic [15:0] in_word_q, in_word_d;
  logic [63:0] in_all_q, in_all_d;
  logic all_vld_q, all_vld_d;
  logic [11:0] ao1_q, ao1_d, ao2_q, ao2_d;
  always_comb
  begin
    st_d = st_q;
    ch_d = ch_q;
    in_word_d = in_word_q;
    in_all_d = in_all_q;
    all_vld_d = 1'b0;
    ao1_d = ao1_q;
    ao2_d = ao2_q;
    if (SCAN_STB)
    begin
      st_d = fault ? ACSS_ST_FAIL : ACSS_ST_RUN;
      if (PTR_MODE)
      begin
        for (int i = 0; i < 4; i++)
          in_all_d[i*16 +: 16] = fault ? 16'h0000 : {4'h0, conv[i]};
        all_vld_d = 1'b1;
      end
      // One channel per scan, rotating over used ones
      in_word_d = 16'h0000;
      in_word_d[`ACSS_BIT_CH_HI] = ch_q[1];
      in_word_d[`ACSS_BIT_CH_LO] = ch_q[0];
      in_word_d[11:0] = fault ? 12'h000 : conv[ch_q];
      in_word_d[`ACSS_BIT_FAIL] = fault;
      in_word_d[`ACSS_BIT_BUSY] = (st_q == ACSS_ST_FIRST) || sync2_q[2];
      ch_d = next_used(ch_q, IN_USED);
      // Low-active selects; both low writes both
      if (!OUT_SEL_N[0])
        ao1_d = OUT_WORD;
      if (!OUT_SEL_N[1])
        ao2_d = OUT_WORD;
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q <= ACSS_ST_FIRST;
      ch_q <= 2'h0;
      in_word_q <= `ACSS_IN_WORD_RST;
      in_all_q <= '0;
      all_vld_q <= 1'b0;
      ao1_q <= 12'h000;
      ao2_q <= 12'h000;
    end
    else
    begin
      st_q <= st_d;
      ch_q <= ch_d;
      in_word_q <= in_word_d;
      in_all_q <= in_all_d;
      all_vld_q <= all_vld_d;
      ao1_q <= ao1_d;
      ao2_q <= ao2_d;
    end
  end
  assign IN_WORD = in_word_q;
  assign IN_ALL = in_all_q;
  assign IN_ALL_VLD = all_vld_q;
  assign AOUT1 = ao1_q;
  assign AOUT2 = ao2_q;
  ////////////////////////////////////////////////////////////////////////////
  // Checker helper: strobes since channel one was shown, all four in use
  logic [2:0] pass_cnt_q, pass_cnt_d;
  always_comb
  begin
    pass_cnt_d = pass_cnt_q;
    if (IN_USED != 4'hf)
      pass_cnt_d = 3'h0;
    else if (SCAN_STB)
    begin
      if (ch_q == 2'h0)
        pass_cnt_d = 3'h1;
      else if (pass_cnt_q != 3'h7)
        pass_cnt_d = 3'(pass_cnt_q + 3'h1);
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pass_cnt_q <= 3'h0;
    end
    else
    begin
      pass_cnt_q <= pass_cnt_d;
    end
  end
  // Strobes may come back to back, so the pulse check needs a quiet cycle
  sequence s_ptr_take;
    SCAN_STB && PTR_MODE;
  endsequence
  sequence s_vld_pulse;
    IN_ALL_VLD ##1 !IN_ALL_VLD;
  endsequence
  AST_FIRST_BUSY: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && st_q == ACSS_ST_FIRST |=> IN_WORD[`ACSS_BIT_BUSY])
    else $error("busy missing on first scan");
  AST_FAIL_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && fault |=> IN_WORD[11:0] == 12'h000 && IN_WORD[`ACSS_BIT_FAIL])
    else $error("fail data not zero");
  AST_CH_CODE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB |=> IN_WORD[15:14] == $past(ch_q))
    else $error("channel code mismatch");
  AST_WRAP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && IN_USED == 4'hF && ch_q == 2'd3 |=> ch_q == 2'd0)
    else $error("no wrap to channel one");
  AST_SKIP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && ch_q == 2'd0 && IN_USED == 4'b0101 |=> ch_q == 2'd2)
    else $error("unused channel not skipped");
  AST_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !SCAN_STB |=> $stable(ch_q) && $stable(AOUT1) && $stable(AOUT2))
    else $error("state moved without strobe");
  AST_OUT1: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && OUT_SEL_N == 2'b10 |=> AOUT1 == $past(OUT_WORD) && $stable(AOUT2))
    else $error("channel one update wrong");
  AST_PTR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    s_ptr_take ##1 !(SCAN_STB && PTR_MODE) |-> s_vld_pulse)
    else $error("pointer burst missing");
  AST_PASS_LEN: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    IN_USED == 4'hf |-> pass_cnt_q < 3'h5)
    else $error("pass longer than four scans");
  AST_STEP_ALL: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && IN_USED == 4'hf |=> ch_q == 2'($past(ch_q) + 2'h1))
    else $error("channel step wrong with all in use");
  AST_ALT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && ch_q == 2'h2 && IN_USED == 4'b0101 |=> ch_q == 2'h0)
    else $error("two channels do not alternate");
  AST_WORD_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !SCAN_STB |=> $stable(IN_WORD))
    else $error("input word moved without strobe");
  AST_OUT2: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && OUT_SEL_N == 2'b01 |=> AOUT2 == $past(OUT_WORD) && $stable(AOUT1))
    else $error("channel two update wrong");
  AST_OUT_BOTH: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && OUT_SEL_N == 2'b00 |=> AOUT1 == $past(OUT_WORD) && AOUT2 == $past(OUT_WORD))
    else $error("shared output write wrong");
  AST_OUT_NONE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && OUT_SEL_N == 2'b11 |=> $stable(AOUT1) && $stable(AOUT2))
    else $error("outputs moved while deselected");
  AST_FAIL_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && !fault |=> !IN_WORD[`ACSS_BIT_FAIL])
    else $error("fail flag stuck");
  AST_BUSY_QUIET: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && st_q != ACSS_ST_FIRST && !sync2_q[2] |=> !IN_WORD[`ACSS_BIT_BUSY])
    else $error("busy without cause");
  AST_PTR_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB && PTR_MODE && fault |=> IN_ALL == 64'h0000_0000_0000_0000)
    else $error("pointer data not zero on fail");
  AST_LEAVE_FIRST: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SCAN_STB |=> st_q != ACSS_ST_FIRST)
    else $error("still in first scan");
endmodule : acss_seq
`default_nettype wire

// file: verif/acss_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller side: a scan strobe every other cycle while a request is held
module acss_ctl_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic kick,
  output logic SCAN_STB
);
  // Never two strobes in a row for one held request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      SCAN_STB <= 1'b0;
    end
    else
    begin
      SCAN_STB <= kick & !SCAN_STB;
    end
  end
endmodule : acss_ctl_model
`default_nettype wire

// file: verif/test_analog_channel_scan_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_analog_channel_scan_sequencer;
  import acss_pkg::*;
  logic clk = 0, rst_n = 0, kick = 0, stb, ptr = 0, pwr = 1, term = 1, vld, noise = 0;
  logic [3:0] used = 4'h0;
  logic [63:0] ma = '0, ia;
  logic [11:0] ow = '0, a1, a2, e1 = '0, e2 = '0;
  logic [1:0] sel = 2'b11;
  logic [15:0] iw;
  integer seed;
  int err_count = 0, cmp_count = 0, i, k;
  acss_ctl_model ctl (.clk(clk), .rst_n(rst_n), .kick(kick), .SCAN_STB(stb));
  acss_seq dut (.CLK_SYS(clk), .RST_N(rst_n), .SCAN_STB(stb), .PTR_MODE(ptr),
    .IN_USED(used), .IN_MA_X16(ma), .PWR_OK_ASYNC(pwr), .TERM_OK_ASYNC(term),
    .NOISE_ASYNC(noise), .OUT_WORD(ow), .OUT_SEL_N(sel), .IN_WORD(iw),
    .IN_ALL(ia), .IN_ALL_VLD(vld), .AOUT1(a1), .AOUT2(a2));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Count for a current in 1/16 mA: 4 mA is zero, clipped at full scale
  function automatic logic [15:0] exp_cnt(input int x);
    int r;
    r = 0;
    if (x > 64)
      r = ((x - 64) >= 256) ? 4095 : (x - 64) * 16;
    else if (x < -64)
      r = -x - 64;
    return 16'(r);
  endfunction : exp_cnt
  // Ends two ns past the taking edge, outputs settled
  task automatic scan;
    @(posedge clk) #2 kick = 1;
    @(posedge clk) #2 kick = 0;
    @(posedge clk) #2;
  endtask : scan
  task automatic wrap_up;
    $display("Compares %0d, errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #60000;
    err_count++;
    wrap_up;
  end
  initial
  begin
    seed = 79;
    repeat (16) @(posedge clk);
    #2 rst_n = 1;
    chk("rst", iw, 16'h1000);
    used = 4'hf;
    scan;
    chk("busy", iw[12], 1'b1);
    for (i = 1; i < 9; i++)
    begin
      ma = {4{16'($random(seed) % 65)}};
      scan;
      chk("chan", iw[15:14], 16'(i % 4));
      chk("zero", iw[11:0], 16'h0000);
    end
    ma = {4{16'hfd80}};
    scan;
    chk("rev", iw[11:0], 16'h0240);
    used = 4'b0101;
    for (i = 0; i < 4; i++)
    begin
      scan;
      chk("skip", iw[15:14], i[0] ? 16'h0000 : 16'h0002);
    end
    // Loose terminals, then missing supply, the second in pointer mode
    for (i = 0; i < 2; i++)
    begin
      {pwr, term} = i[0] ? 2'b01 : 2'b10;
      ptr = i[0];
      repeat (3) @(posedge clk);
      scan;
      chk("fail", {iw[13], iw[11:0]}, 16'h1000);
      chk("fall", ia[63:48], 16'h0000);
      {pwr, term} = 2'b11;
      ptr = 1'b0;
      repeat (3) @(posedge clk);
      scan;
      chk("clear", iw[13], 1'b0);
    end
    noise = 1;
    repeat (3) @(posedge clk);
    scan;
    chk("noise", iw[12], 1'b1);
    noise = 0;
    repeat (3) @(posedge clk);
    scan;
    chk("quiet", iw[12], 1'b0);
    ptr = 1;
    scan;
    chk("vld", vld, 1'b1);
    chk("all", ia[63:48], 16'h0240);
    @(posedge clk) #2 chk("pulse", vld, 1'b0);
    // Random live currents, last pass the hand-set corners
    for (i = 0; i < 6; i++)
    begin
      for (k = 0; k < 4; k++)
        ma[k*16 +: 16] = 16'(64 + (($random(seed) & 32'h0000_01ff) % 300));
      if (i == 5)
        ma = {16'hfd80, 16'h0140, 16'h0041, 16'h0040};
      scan;
      for (k = 0; k < 4; k++)
        chk("word", ia[k*16 +: 16], exp_cnt($signed(ma[k*16 +: 16])));
    end
    ptr = 0;
    // Every select code twice, fresh random word each time
    for (i = 0; i < 8; i++)
    begin
      sel = i[1:0];
      ow = 12'($random(seed));
      e1 = sel[0] ? e1 : ow;
      e2 = sel[1] ? e2 : ow;
      scan;
      chk("out1", a1, e1);
      chk("out2", a2, e2);
    end
    wrap_up;
  end
endmodule : test_analog_channel_scan_sequencer
`default_nettype wire
